// ==== rtl/slm_conv_if.sv ====
/*
 * Interface between the sequencer and its period timer.
 * Assumes both ends share ref_clk_i.
 */
`timescale 1ns/1ps
interface slm_conv_if;
	logic tick;
	logic run;
	modport timer (output tick, input run);
	modport seq (input tick, output run);
endinterface

// ==== rtl/slm_period_timer.sv ====
/*
 * Period timer: pulses tick once every period_i+1 cycles.
 * Assumes period_i is stable while running; zero ticks every cycle.
 */
`timescale 1ns/1ps
module slm_period_timer
	import slm_pkg::*;
#(
	parameter int W = PERIOD_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] period_i,
	slm_conv_if.timer bus
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic tick_ff;
	logic hit;
	assign hit = (cnt_ff == '0);
	assign nxt_cnt = hit ? period_i : cnt_ff - W'(1);
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (!bus.run) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= hit;
		end
	end
	assign bus.tick = tick_ff;
endmodule // slm_period_timer

// ==== rtl/slm_pkg.sv ====
/*
 * Constants shared by the supply level monitor sequencer.
 * Assumes a single 100 MHz clock domain.
 */
package slm_pkg;
	localparam int NUM_CH = 14;
	localparam int VOLT_CH_LAST = 10;
	localparam int DATA_W = 8;
	localparam int CH_W = 4;
	localparam int PERIOD_W = 24;
	localparam int DELAY_W = 16;
	localparam logic [CH_W-1:0] FIRST_CH = 4'h0;
	localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
	localparam logic [CH_W-1:0] BANK_RST = 4'h0;
	typedef enum logic [2:0] {
		SLM_IDLE = 3'b000,
		SLM_START = 3'b001,
		SLM_WAIT = 3'b010,
		SLM_SETTLE = 3'b011,
		SLM_NEXT = 3'b100
	} slm_state_t;
endpackage

// ==== rtl/slm_seq.sv ====
/*
 * Supply level monitor sequencer: scans enabled channels, stores readouts,
 * checks limits, keeps sticky flags and drives alarm, SMI and IRQ.
 * Assumes an external converter with start/done handshake on ref_clk_i
 * and that software clear pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
module slm_seq
	import slm_pkg::*;
#(
	parameter int NCH = NUM_CH,
	parameter int PW = PERIOD_W,
	parameter int DW = DELAY_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic monitor_enable_i,
	input wire logic standby_i,
	input wire logic sleep_state_input_n_i,
	input wire logic error_i,
	input wire logic [PW-1:0] period_i,
	input wire logic [DW-1:0] settle_i,
	input wire logic [slm_pkg::NUM_CH-1:0] ch_enable_i,
	input wire logic [slm_pkg::NUM_CH-1:0] alarm_enable_i,
	input wire logic [slm_pkg::NUM_CH-1:0] event_to_sysmgmt_i,
	input wire logic [slm_pkg::NUM_CH-1:0] event_to_irq_i,
	input wire logic [slm_pkg::NUM_CH*slm_pkg::DATA_W-1:0] high_limit_i,
	input wire logic [slm_pkg::NUM_CH*slm_pkg::DATA_W-1:0] low_limit_i,
	input wire logic [slm_pkg::NUM_CH-1:0] clear_high_i,
	input wire logic [slm_pkg::NUM_CH-1:0] clear_low_i,
	input wire logic [slm_pkg::CH_W-1:0] channel_bank_select_i,
	input wire logic bank_select_we_i,
	input wire logic conv_done_i,
	input wire logic [slm_pkg::DATA_W-1:0] conv_data_i,
	output logic conv_start_o,
	output logic [slm_pkg::CH_W-1:0] conv_ch_o,
	output logic busy_o,
	output logic [slm_pkg::CH_W-1:0] bank_o,
	output logic [slm_pkg::DATA_W-1:0] channel_readout_o,
	output logic [slm_pkg::DATA_W-1:0] bank_high_limit_o,
	output logic [slm_pkg::DATA_W-1:0] bank_low_limit_o,
	output logic [1:0] bank_flags_o,
	output logic [slm_pkg::NUM_CH-1:0] high_flags_o,
	output logic [slm_pkg::NUM_CH-1:0] low_flags_o,
	output logic [slm_pkg::NUM_CH-1:0] event_flags_o,
	output logic alarm_o,
	output logic sysmgmt_int_o,
	output logic irq_o
);
	import slm_pkg::*;

	slm_conv_if cif();

	slm_period_timer #(.W(PW)) u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.period_i(period_i),
		.bus(cif.timer)
	);

	// Pin inputs pass two flops; stage one feeds only stage two
	logic slp_m_ff;
	logic slp_ff;
	logic err_m_ff;
	logic err_ff;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slp_m_ff <= 1'b1;
			slp_ff <= 1'b1;
			err_m_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			slp_m_ff <= sleep_state_input_n_i;
			slp_ff <= slp_m_ff;
			err_m_ff <= error_i;
			err_ff <= err_m_ff;
		end
	end

	slm_state_t state_ff;
	slm_state_t nxt_state;
	logic [CH_W-1:0] ch_ff;
	logic [DW-1:0] dly_ff;
	logic start_ff;
	logic [DATA_W-1:0] rd_ff [NCH];
	logic [NCH-1:0] hi_ff;
	logic [NCH-1:0] lo_ff;
	logic [NCH-1:0] ev_ff;
	logic [CH_W-1:0] bank_ff;
	logic alarm_ff;
	logic smi_ff;
	logic irq_ff;
	logic busy_ff;
	logic [DATA_W-1:0] rdo_ff;
	logic [DATA_W-1:0] bhi_ff;
	logic [DATA_W-1:0] blo_ff;
	logic [1:0] bfl_ff;

	// Suspend keeps failure evidence intact while supplies may be falling
	logic suspend;
	assign suspend = !slp_ff || err_ff;
	assign cif.run = monitor_enable_i && !standby_i && !suspend;

	// Out-of-range voltage channels are frozen so their readouts are not lost
	logic [NCH-1:0] eligible;
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_elig
			if (gi <= VOLT_CH_LAST) begin : g_v
				assign eligible[gi] = ch_enable_i[gi] && !hi_ff[gi] && !lo_ff[gi];
			end else begin : g_t
				assign eligible[gi] = ch_enable_i[gi];
			end
		end
	endgenerate

	// Lowest eligible channel at or above a start index
	function automatic logic [CH_W:0] find_from(input logic [NCH-1:0] el,
			input logic [CH_W:0] from);
		logic [CH_W:0] r;
		r = (CH_W+1)'(NCH);
		for (int k = NCH - 1; k >= 0; k--) begin
			if (el[k] && (CH_W+1)'(k) >= from) begin
				r = (CH_W+1)'(k);
			end
		end
		return r;
	endfunction

	logic [CH_W:0] first_ch;
	logic [CH_W:0] next_ch;
	assign first_ch = find_from(eligible, {1'b0, FIRST_CH});
	assign next_ch = find_from(eligible, {1'b0, ch_ff} + (CH_W+1)'(1));
	logic have_first;
	logic have_next;
	assign have_first = first_ch < (CH_W+1)'(NCH);
	assign have_next = next_ch < (CH_W+1)'(NCH);

	// One channel's byte out of a packed limit vector
	function automatic logic [DATA_W-1:0] lane(input logic [NCH*DATA_W-1:0] v,
			input logic [CH_W-1:0] c);
		return v[c*DATA_W +: DATA_W];
	endfunction

	logic [DATA_W-1:0] cur_hi;
	logic [DATA_W-1:0] cur_lo;
	assign cur_hi = lane(high_limit_i, ch_ff);
	assign cur_lo = lane(low_limit_i, ch_ff);

	// Bank view and output levels, registered below
	logic [DATA_W-1:0] nxt_rdo;
	logic [DATA_W-1:0] nxt_bhi;
	logic [DATA_W-1:0] nxt_blo;
	logic [1:0] nxt_bfl;
	logic nxt_alarm;
	logic nxt_smi;
	logic nxt_irq;
	assign nxt_rdo = rd_ff[bank_ff];
	assign nxt_bhi = lane(high_limit_i, bank_ff);
	assign nxt_blo = lane(low_limit_i, bank_ff);
	assign nxt_bfl = {hi_ff[bank_ff], lo_ff[bank_ff]};
	assign nxt_alarm = |(alarm_enable_i & (hi_ff | lo_ff));
	assign nxt_smi = |(ev_ff & event_to_sysmgmt_i);
	assign nxt_irq = |(ev_ff & event_to_irq_i);
	logic take;
	assign take = (state_ff == SLM_WAIT) && conv_done_i && !suspend;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SLM_IDLE: begin
				if (cif.tick && cif.run && have_first) begin
					nxt_state = SLM_START;
				end
			end
			SLM_START: nxt_state = SLM_WAIT;
			SLM_WAIT: begin
				if (conv_done_i) begin
					nxt_state = have_next ? SLM_SETTLE : SLM_IDLE;
				end
			end
			SLM_SETTLE: begin
				if (dly_ff == '0) begin
					nxt_state = SLM_NEXT;
				end
			end
			SLM_NEXT: nxt_state = (!cif.run || !have_next) ? SLM_IDLE : SLM_START;
			default: nxt_state = SLM_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= SLM_IDLE;
			ch_ff <= FIRST_CH;
			dly_ff <= '0;
			start_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_ff <= (nxt_state != SLM_IDLE);
			start_ff <= (nxt_state == SLM_START) && !suspend;
			if (state_ff == SLM_IDLE && nxt_state == SLM_START) begin
				ch_ff <= first_ch[CH_W-1:0];
			end else if (state_ff == SLM_NEXT && nxt_state == SLM_START) begin
				ch_ff <= next_ch[CH_W-1:0];
			end
			if (state_ff == SLM_WAIT) begin
				dly_ff <= settle_i;
			end else if (dly_ff != '0) begin
				dly_ff <= dly_ff - DW'(1);
			end
		end
	end

	// Per-channel readout and sticky limit flags; set beats clear
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			logic hit;
			logic set_hi;
			logic set_lo;
			assign hit = take && (ch_ff == CH_W'(gi));
			assign set_hi = hit && (conv_data_i > cur_hi);
			assign set_lo = hit && (conv_data_i < cur_lo);
			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					rd_ff[gi] <= ZERO_DATA;
					hi_ff[gi] <= 1'b0;
					lo_ff[gi] <= 1'b0;
					ev_ff[gi] <= 1'b0;
				end else begin
					if (hit) begin
						rd_ff[gi] <= conv_data_i;
					end
					hi_ff[gi] <= set_hi || (hi_ff[gi] && !clear_high_i[gi]);
					lo_ff[gi] <= set_lo || (lo_ff[gi] && !clear_low_i[gi]);
					ev_ff[gi] <= set_hi || set_lo ||
						(hi_ff[gi] && !clear_high_i[gi]) ||
						(lo_ff[gi] && !clear_low_i[gi]);
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bank_ff <= BANK_RST;
			alarm_ff <= 1'b0;
			smi_ff <= 1'b0;
			irq_ff <= 1'b0;
			rdo_ff <= ZERO_DATA;
			bhi_ff <= ZERO_DATA;
			blo_ff <= ZERO_DATA;
			bfl_ff <= 2'b00;
		end else begin
			if (bank_select_we_i && channel_bank_select_i < CH_W'(NCH)) begin
				bank_ff <= channel_bank_select_i;
			end
			alarm_ff <= nxt_alarm;
			smi_ff <= nxt_smi;
			irq_ff <= nxt_irq;
			rdo_ff <= nxt_rdo;
			bhi_ff <= nxt_bhi;
			blo_ff <= nxt_blo;
			bfl_ff <= nxt_bfl;
		end
	end

	assign conv_start_o = start_ff;
	assign conv_ch_o = ch_ff;
	assign busy_o = busy_ff;
	assign bank_o = bank_ff;
	assign channel_readout_o = rdo_ff;
	assign bank_high_limit_o = bhi_ff;
	assign bank_low_limit_o = blo_ff;
	assign bank_flags_o = bfl_ff;
	assign high_flags_o = hi_ff;
	assign low_flags_o = lo_ff;
	assign event_flags_o = ev_ff;
	assign alarm_o = alarm_ff;
	assign sysmgmt_int_o = smi_ff;
	assign irq_o = irq_ff;
endmodule // slm_seq

// ==== tb/slm_conv_model.sv ====
/* Converter model: done and data come lat_i+2 cycles after start.
 Assumes start is a one-cycle pulse on ref_clk_i. */
`timescale 1ns/1ps
module slm_conv_model (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [3:0] ch_i,
	input wire logic [111:0] volts_i,
	input wire logic [2:0] lat_i,
	output logic done_o,
	output logic [7:0] data_o
);
	logic [3:0] cnt_ff;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 4'h0;
			done_o <= 1'b0;
			data_o <= 8'h5a;
		end else begin
			done_o <= cnt_ff == 4'h1;
			// Toggles outside done so late sampling shows up
			data_o <= cnt_ff == 4'h1 ? volts_i[ch_i*8+:8] : ~data_o;
			cnt_ff <= start_i ? {1'b0, lat_i} + 4'h1 : cnt_ff - {3'h0, cnt_ff != 4'h0};
		end
	end
endmodule // slm_conv_model

// ==== tb/slm_seq_asserts.sv ====
/* Concurrent checks on the slm_seq ports.
 Assumes one clock domain and the bind below. */
`timescale 1ns/1ps
module slm_seq_chk
	import slm_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [slm_pkg::NUM_CH-1:0] ch_enable_i,
	input wire logic [slm_pkg::NUM_CH-1:0] alarm_enable_i,
	input wire logic [slm_pkg::NUM_CH-1:0] event_to_sysmgmt_i,
	input wire logic [slm_pkg::NUM_CH-1:0] event_to_irq_i,
	input wire logic [slm_pkg::NUM_CH-1:0] clear_high_i,
	input wire logic [slm_pkg::NUM_CH-1:0] clear_low_i,
	input wire logic conv_start_o,
	input wire logic [slm_pkg::CH_W-1:0] conv_ch_o,
	input wire logic busy_o,
	input wire logic [slm_pkg::CH_W-1:0] bank_o,
	input wire logic [slm_pkg::NUM_CH-1:0] high_flags_o,
	input wire logic [slm_pkg::NUM_CH-1:0] low_flags_o,
	input wire logic [slm_pkg::NUM_CH-1:0] event_flags_o,
	input wire logic alarm_o,
	input wire logic sysmgmt_int_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire [NUM_CH-1:0] any_f = high_flags_o | low_flags_o;
	wire al_w = |(event_flags_o & alarm_enable_i);
	wire sm_w = |(event_flags_o & event_to_sysmgmt_i);
	wire iq_w = |(event_flags_o & event_to_irq_i);
	a_high_sticky: assert property (1 |=>
		($past(high_flags_o) & ~$past(clear_high_i) & ~high_flags_o) == '0)
		else $error("high flag dropped without clear");
	a_low_sticky: assert property (1 |=>
		($past(low_flags_o) & ~$past(clear_low_i) & ~low_flags_o) == '0)
		else $error("low flag dropped without clear");
	a_event_follow: assert property (event_flags_o == any_f)
		else $error("event flags do not follow limit flags");
	a_alarm_gate: assert property (1 |=> alarm_o == $past(al_w))
		else $error("alarm level wrong");
	a_smi_gate: assert property (1 |=> sysmgmt_int_o == $past(sm_w))
		else $error("sysmgmt level wrong");
	a_irq_gate: assert property (1 |=> irq_o == $past(iq_w))
		else $error("irq level wrong");
	a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than one cycle");
	a_skip_flagged: assert property (conv_start_o |-> busy_o &&
		ch_enable_i[conv_ch_o] &&
		!(conv_ch_o <= CH_W'(VOLT_CH_LAST) && any_f[conv_ch_o]))
		else $error("start on disabled or flagged channel");
	a_bank_range: assert property (bank_o < CH_W'(NUM_CH))
		else $error("bank out of range");
endmodule // slm_seq_chk
bind slm_seq slm_seq_chk u_chk (.*);

// ==== tb/voltage_level_monitor_seq_bench.sv ====
/* Random bench for slm_seq with a converter model.
 Assumes the package, interface, model and checker are compiled first. */
`timescale 1ns/1ps
module voltage_level_monitor_seq_bench;
	import slm_pkg::*;
	logic ref_clk_i = 0, rst_n_i = 0, monitor_enable_i = 0, standby_i = 0, error_i = 0;
	logic sleep_state_input_n_i = 1, bank_select_we_i = 0, conv_done_i, conv_start_o, busy_o;
	logic alarm_o, sysmgmt_int_o, irq_o;
	logic [23:0] period_i = 24'h32;
	logic [15:0] settle_i = 16'h0;
	logic [13:0] ch_enable_i = 0, alarm_enable_i = 0, event_to_sysmgmt_i = 0, event_to_irq_i = 0;
	logic [13:0] clear_high_i = 0, clear_low_i = 0, eh, el, high_flags_o, low_flags_o, event_flags_o;
	logic [111:0] high_limit_i = 0, low_limit_i = 0, volts = 0;
	logic [127:0] t;
	logic [7:0] conv_data_i, channel_readout_o, bank_high_limit_o, bank_low_limit_o;
	logic [3:0] conv_ch_o, bank_o, channel_bank_select_i = 0, firstch, lowest;
	logic [2:0] lat = 0, ex3;
	logic [7:0] rd_exp;
	logic [1:0] bank_flags_o;
	logic [31:0] lfsr = 32'h84ba4f14;
	int fail_count = 0, check_count = 0, starts = 0, gap = 0, lastch = -1;
	slm_seq DUT (.*);
	slm_conv_model u_conv (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(conv_start_o),
		.ch_i(conv_ch_o), .volts_i(volts), .lat_i(lat), .done_o(conv_done_i), .data_o(conv_data_i));
	always #5 ref_clk_i = ~ref_clk_i;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [13:0] over(input logic [111:0] a, input logic [111:0] b);
		for (int i = 0; i < 14; i++) over[i] = ch_enable_i[i] && a[i*8+:8] > b[i*8+:8];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic ld(input logic [3:0] b);
		channel_bank_select_i = b;
		bank_select_we_i = 1;
		cyc(1);
		bank_select_we_i = 0;
		cyc(3);
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Sampled at the falling edge, clear of the design's own updates
	always @(negedge ref_clk_i) begin
		gap = conv_done_i ? 0 : gap + 1;
		if (busy_o !== 1'b1) lastch = -1;
		if (conv_start_o === 1'b1) begin
			if (starts == 0) firstch = conv_ch_o;
			if (lastch >= 0) chk(conv_ch_o > lastch, 1);
			if (lastch >= 0) chk(gap, int'(settle_i) + 3);
			lastch = conv_ch_o;
			starts++;
		end
	end
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial begin
		cyc(12);
		rst_n_i = 1;
		for (int r = 0; r < 6; r++) begin
			t = {rnd(), rnd(), rnd(), rnd()};
			volts = t[111:0];
			t = {rnd(), rnd(), rnd(), rnd()};
			high_limit_i = t[111:0] | {14{8'h80}};
			low_limit_i = t[127:16] & {14{8'h7f}};
			t = {rnd(), rnd(), rnd(), rnd()};
			{ch_enable_i, alarm_enable_i, event_to_sysmgmt_i, event_to_irq_i} = t[55:0];
			ch_enable_i[r] = 1;
			ch_enable_i[r+8] = 1;
			// Corners: readings equal to a limit are in range
			if (r == 3) begin
				ch_enable_i[0] = 1;
				volts[7:0] = high_limit_i[7:0];
			end
			if (r == 4) begin
				ch_enable_i[1] = 1;
				volts[15:8] = low_limit_i[15:8];
			end
			lat = t[58:56];
			settle_i = 16'(r);
			sleep_state_input_n_i = r != 0;
			standby_i = r == 1;
			error_i = r == 2;
			starts = 0;
			firstch = 4'hf;
			cyc(3);
			monitor_enable_i = 1;
			cyc(600);
			monitor_enable_i = 0;
			for (int i = 0; i < 300 && busy_o !== 1'b0; i++) cyc(1);
			chk(busy_o, 0);
			cyc(4);
			eh = r < 3 ? 14'h0 : over(volts, high_limit_i);
			el = r < 3 ? 14'h0 : over(low_limit_i, volts);
			for (int i = 13; i >= 0; i--) if (ch_enable_i[i]) lowest = 4'(i);
			if (r < 3) chk(starts, 0);
			else chk(firstch, lowest);
			chk(high_flags_o, eh);
			chk(low_flags_o, el);
			chk(event_flags_o, eh | el);
			ex3 = {|((eh | el) & alarm_enable_i), |((eh | el) & event_to_sysmgmt_i), 1'b0};
			ex3[0] = |((eh | el) & event_to_irq_i);
			chk({alarm_o, sysmgmt_int_o, irq_o}, ex3);
			ld(4'(r + 8));
			chk(bank_o, r + 8);
			// Channels 8 to 10 are never converted in the suspended and standby rounds
			rd_exp = r > 2 ? volts[(r+8)*8+:8] : ZERO_DATA;
			chk({channel_readout_o, bank_flags_o}, {rd_exp, eh[r+8], el[r+8]});
			chk(bank_high_limit_o, high_limit_i[(r+8)*8+:8]);
			chk(bank_low_limit_o, low_limit_i[(r+8)*8+:8]);
			ld(4'hf);
			chk(bank_o, r + 8);
			clear_high_i = event_flags_o & high_flags_o;
			clear_low_i = event_flags_o & low_flags_o;
			cyc(1);
			clear_high_i = 0;
			clear_low_i = 0;
			cyc(4);
			chk(event_flags_o | high_flags_o | low_flags_o, 0);
			chk({alarm_o, sysmgmt_int_o, irq_o}, 0);
		end
		print_verdict();
	end
endmodule // voltage_level_monitor_seq_bench
